/* File: test_usb_host_global_irq.sv */
// Self-checking bench of the host global interrupt block
`timescale 1ns/1ps

module test_usb_host_global_irq;
	import uhgi_pkg::*;
	// ==========================================================
	// Signals
	logic        sys_clk_i = 1'b0;
	logic        reset_i   = 1'b1;
	logic        hsel      = 1'b0;
	logic        hwrite    = 1'b0;
	logic [1:0]  htrans    = 2'h0;
	logic [31:0] haddr     = 32'h00000000;
	logic [31:0] hwdata    = 32'h00000000;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        irq;
	logic        fire      = 1'b0;
	logic [2:0]  sel       = 3'h0;
	logic [6:0]  ev;
	logic        low_speed = 1'b1;
	logic        fgo       = 1'b1;
	logic        bpr       = 1'b0;
	logic        freeze    = 1'b0;
	logic [8:0]  pipes     = 9'h000;
	int          num_errors  = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	always #25 sys_clk_i = ~sys_clk_i;

	uhgi_ctrl u_uhgi_ctrl (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.frame_start_i(ev[5]), .keep_alive_i(ev[6]), .resume_rx_i(ev[4]),
		.resume_done_i(ev[3]), .reset_done_i(ev[2]), .detach_i(ev[1]), .attach_i(ev[0]),
		.low_speed_i(low_speed), .frame_generation_on_i(fgo), .bus_power_request_i(bpr),
		.clock_freeze_i(freeze), .pipe_status_i(pipes), .irq_o(irq));

	uhgi_dev_model u_uhgi_dev_model (.sys_clk_i(sys_clk_i), .fire_i(fire), .sel_i(sel),
		.event_o(ev));

	// ==========================================================
	// Shared tasks
	task tally_and_finish;
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Read data is taken at the edge that ends the data phase, before it updates
	task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk_i);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {20'h00000, a};
		do @(posedge sys_clk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk_i); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h00000000, q);
		check(q, exp);
	endtask : rdchk

	task pulse(input logic [2:0] s);
		@(posedge sys_clk_i);
		fire <= 1'b1;
		sel <= s;
		@(posedge sys_clk_i);
		fire <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask : pulse

	// ==========================================================
	// Scenarios
	task t_reset;
		rdchk(OFS_IRQ_EN, 32'h00000000);
		rdchk(OFS_FLAGS, 32'h00000000);
		rdchk(12'h420, 32'h00000000);
		check({31'h0, irq}, 32'h00000000);
		check({31'h0, hresp}, 32'h00000000);
	endtask : t_reset

	task t_rerun;
		wr(OFS_EN_SET, 32'h0000007f);
		wr(OFS_FLAG_SET, 32'h0000007f);
		@(posedge sys_clk_i);
		check({31'h0, irq}, 32'h00000001);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rdchk(OFS_IRQ_EN, 32'h00000000);
		rdchk(OFS_FLAGS, 32'h00000000);
		check({31'h0, irq}, 32'h00000000);
	endtask : t_rerun

	task t_soft;
		wr(OFS_FLAG_SET, 32'hffffffff);
		rdchk(OFS_FLAGS, 32'h0000007f);
		wr(OFS_FLAG_CLR, 32'h00000015);
		rdchk(OFS_FLAGS, 32'h0000006a);
		wr(OFS_FLAG_CLR, 32'h00000000);
		rdchk(OFS_FLAGS, 32'h0000006a);
		wr(OFS_FLAG_CLR, 32'h0000007f);
	endtask : t_soft

	task t_events;
		for (int s = 0; s < 7; s++) begin
			pulse(s[2:0]);
			rdchk(OFS_FLAGS, 32'h1 << ((s == 6) ? 5 : s));
			wr(OFS_FLAG_CLR, 32'h0000007f);
		end
		low_speed <= 1'b0;
		pulse(3'h6);
		rdchk(OFS_FLAGS, 32'h00000000);
		fgo <= 1'b0;
		pulse(3'h4);
		rdchk(OFS_FLAGS, 32'h00000050);
		wr(OFS_FLAG_CLR, 32'h0000007f);
		pulse(3'h1);
		rdchk(OFS_FLAGS, 32'h00000042);
		wr(OFS_FLAG_CLR, 32'h0000007f);
		freeze <= 1'b1;
		bpr <= 1'b1;
		pulse(3'h0);
		rdchk(OFS_FLAGS, 32'h00000040);
		freeze <= 1'b0;
		wr(OFS_FLAG_CLR, 32'h0000007f);
	endtask : t_events

	task t_irq;
		wr(OFS_FLAG_SET, 32'h00000020);
		@(posedge sys_clk_i);
		check({31'h0, irq}, 32'h00000000);
		wr(OFS_EN_SET, 32'h00000020);
		rdchk(OFS_IRQ_EN, 32'h00000020);
		check({31'h0, irq}, 32'h00000001);
		wr(OFS_IRQ_EN, 32'hffffffff);
		rdchk(OFS_IRQ_EN, 32'h00000020);
		wr(OFS_EN_CLR, 32'h00000020);
		rdchk(OFS_IRQ_EN, 32'h00000000);
		check({31'h0, irq}, 32'h00000000);
		pipes <= 9'h001;
		wr(OFS_EN_SET, 32'h0001ff7f);
		rdchk(OFS_IRQ_EN, 32'h0001ff7f);
		wr(OFS_EN_CLR, 32'h0000feff);
		rdchk(OFS_FLAGS, 32'h00000120);
		check({31'h0, irq}, 32'h00000001);
		pipes <= 9'h000;
		wr(OFS_FLAG_CLR, 32'h0000007f);
		rdchk(OFS_IRQ_EN, 32'h00010100);
		check({31'h0, irq}, 32'h00000000);
	endtask : t_irq

	// ==========================================================
	// Main sequence and hang guard
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_soft();
		t_events();
		t_irq();
		t_rerun();
		tally_and_finish();
	end
endmodule : test_usb_host_global_irq

/* File: uhgi_ctrl.sv */
// Global interrupt flags and enables of the USB host, AHB-Lite slave
`timescale 1ns/1ps

module uhgi_ctrl (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Host controller events, one-cycle pulses
	input  wire logic        frame_start_i,
	input  wire logic        keep_alive_i,
	input  wire logic        resume_rx_i,
	input  wire logic        resume_done_i,
	input  wire logic        reset_done_i,
	input  wire logic        detach_i,
	input  wire logic        attach_i,
	// Host controller levels
	input  wire logic        low_speed_i,
	input  wire logic        frame_generation_on_i,
	input  wire logic        bus_power_request_i,
	input  wire logic        clock_freeze_i,
	input  wire logic [uhgi_pkg::NUM_PIPES-1:0] pipe_status_i,
	// Interrupt
	output logic             irq_o
);
	import uhgi_pkg::*;

	uhgi_state_s st_reg;
	uhgi_state_s st_next;

	logic                accept;
	logic [GLOBAL_W-1:0] events;
	logic [GLOBAL_W-1:0] flag_clr;
	logic [GLOBAL_W-1:0] flag_set;
	logic [FLAG_W-1:0]   en_clr;
	logic [FLAG_W-1:0]   en_set;
	logic [GLOBAL_W-1:0] clr_only;
	logic [FLAG_W-1:0]   clr_en_only;
	logic                wake_event;

	function automatic logic reg_hit(input logic [9:0] idx, input logic [11:0] ofs);
		reg_hit = (idx == ofs[11:2]);
	endfunction : reg_hit

	// ==========================================================
	// Next state
	always_comb begin
		st_next    = st_reg;
		accept     = hsel_i & htrans_i[1] & hready_i;
		events     = '0;
		flag_clr   = '0;
		flag_set   = '0;
		en_clr     = '0;
		en_set     = '0;
		// Suspend means frame generation off; powered means bus power requested
		wake_event = ((resume_rx_i | detach_i) & ~frame_generation_on_i)
			| (attach_i & bus_power_request_i);
		// A frozen clock stops controller events but not the wake detection
		if (!clock_freeze_i) begin
			events[BIT_FRAME]    = frame_start_i | (low_speed_i & keep_alive_i);
			events[BIT_RSM_RX]   = resume_rx_i;
			events[BIT_RSM_SENT] = resume_done_i;
			events[BIT_RST_SENT] = reset_done_i;
			events[BIT_DETACH]   = detach_i;
			events[BIT_ATTACH]   = attach_i;
		end
		events[BIT_WAKE] = wake_event;

		// Write data phase, address latched one cycle earlier
		if (st_reg.wr_pend) begin
			if (reg_hit(st_reg.wr_idx, OFS_FLAG_CLR))
				flag_clr = hwdata_i[GLOBAL_W-1:0];
			if (reg_hit(st_reg.wr_idx, OFS_FLAG_SET))
				flag_set = hwdata_i[GLOBAL_W-1:0];
			if (reg_hit(st_reg.wr_idx, OFS_EN_CLR))
				en_clr = hwdata_i[FLAG_W-1:0] & VALID_MASK;
			if (reg_hit(st_reg.wr_idx, OFS_EN_SET))
				en_set = hwdata_i[FLAG_W-1:0] & VALID_MASK;
		end
		clr_only    = flag_clr & ~flag_set & ~events;
		clr_en_only = en_clr & ~en_set;

		// Hardware set wins over a clear in the same cycle
		st_next.flags[GLOBAL_W-1:0] = (st_reg.flags[GLOBAL_W-1:0] & ~flag_clr)
			| flag_set | events;
		st_next.flags[GLOBAL_W] = 1'b0;
		st_next.flags[PIPE_MSB:PIPE_LSB] = pipe_status_i;
		// Enable register only moves through its clear and set writes
		st_next.enable = (st_reg.enable & ~en_clr) | en_set;

		// Address phase
		st_next.ready   = 1'b1;
		st_next.wr_pend = accept & hwrite_i;
		st_next.wr_idx  = haddr_i[11:2];
		st_next.rdata   = 32'h00000000;
		// Reads see the effect of a write in the preceding data phase
		if (accept && !hwrite_i) begin
			if (reg_hit(haddr_i[11:2], OFS_FLAGS))
				st_next.rdata = {{(32-FLAG_W){1'b0}}, st_next.flags};
			else if (reg_hit(haddr_i[11:2], OFS_IRQ_EN))
				st_next.rdata = {{(32-FLAG_W){1'b0}}, st_next.enable};
		end

		st_next.irq = |(st_next.flags & st_next.enable);
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			st_reg <= RESET_STATE;
		else
			st_reg <= st_next;
	end

	// Unmapped or write-only reads return zero with OKAY; no wait states
	assign hrdata_o    = st_reg.rdata;
	assign hreadyout_o = st_reg.ready;
	assign hresp_o     = HRESP_OKAY;
	assign irq_o       = st_reg.irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	property p_frame;
		frame_start_i && !clock_freeze_i |=> st_reg.flags[BIT_FRAME];
	endproperty
	a_frame: assert property (p_frame) else $error("frame start flag not set");

	property p_keep_alive;
		keep_alive_i && low_speed_i && !clock_freeze_i |=> st_reg.flags[BIT_FRAME];
	endproperty
	a_keep_alive: assert property (p_keep_alive) else $error("keep-alive not flagged");

	property p_rsm_rx;
		resume_rx_i && !clock_freeze_i |=> st_reg.flags[BIT_RSM_RX];
	endproperty
	a_rsm_rx: assert property (p_rsm_rx) else $error("resume rx flag not set");

	property p_rsm_sent;
		resume_done_i && !clock_freeze_i |=> st_reg.flags[BIT_RSM_SENT];
	endproperty
	a_rsm_sent: assert property (p_rsm_sent) else $error("resume sent flag not set");

	property p_rst_sent;
		reset_done_i && !clock_freeze_i |=> st_reg.flags[BIT_RST_SENT];
	endproperty
	a_rst_sent: assert property (p_rst_sent) else $error("reset sent flag not set");

	property p_detach;
		detach_i && !clock_freeze_i |=> st_reg.flags[BIT_DETACH];
	endproperty
	a_detach: assert property (p_detach) else $error("detach flag not set");

	property p_attach;
		attach_i && !clock_freeze_i |=> st_reg.flags[BIT_ATTACH];
	endproperty
	a_attach: assert property (p_attach) else $error("attach flag not set");

	property p_clear;
		|clr_only |=> (st_reg.flags[GLOBAL_W-1:0] & $past(clr_only)) == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear write ignored");

	property p_set;
		|flag_set |=> (st_reg.flags[GLOBAL_W-1:0] & $past(flag_set)) == $past(flag_set);
	endproperty
	a_set: assert property (p_set) else $error("flag set write ignored");

	property p_frame_mask;
		!st_reg.enable[BIT_FRAME] && st_reg.flags == (17'h1 << BIT_FRAME) |-> !irq_o;
	endproperty
	a_frame_mask: assert property (p_frame_mask) else $error("masked frame irq");

	property p_en_stable;
		!(st_reg.wr_pend && (reg_hit(st_reg.wr_idx, OFS_EN_CLR)
			|| reg_hit(st_reg.wr_idx, OFS_EN_SET))) |=> $stable(st_reg.enable);
	endproperty
	a_en_stable: assert property (p_en_stable) else $error("enable moved");

	property p_en_set;
		|en_set |=> (st_reg.enable & $past(en_set)) == $past(en_set);
	endproperty
	a_en_set: assert property (p_en_set) else $error("enable set ignored");

	property p_en_clr;
		|clr_en_only |=> (st_reg.enable & $past(clr_en_only)) == '0;
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enable clear ignored");

	property p_wake;
		wake_event |=> st_reg.flags[BIT_WAKE];
	endproperty
	a_wake: assert property (p_wake) else $error("wake flag not set");

	property p_wake_frozen;
		clock_freeze_i && attach_i && bus_power_request_i |=> st_reg.flags[BIT_WAKE];
	endproperty
	a_wake_frozen: assert property (p_wake_frozen) else $error("wake lost frozen");

	property p_pipe;
		##1 st_reg.flags[PIPE_MSB:PIPE_LSB] == $past(pipe_status_i);
	endproperty
	a_pipe: assert property (p_pipe) else $error("pipe flag mismatch");

	property p_irq;
		irq_o == |(st_reg.flags & st_reg.enable);
	endproperty
	a_irq: assert property (p_irq) else $error("irq not flag and enable");

	// ==========================================================
	// Bus, read-back and precedence checks
	// Enables may be cleared in the same cycle, so irq checks exclude that case
	property p_hready;
		hreadyout_o == 1'b1;
	endproperty
	a_hready: assert property (p_hready) else $error("wait state inserted");

	property p_hresp;
		hresp_o == HRESP_OKAY;
	endproperty
	a_hresp: assert property (p_hresp) else $error("response not okay");

	property p_rdata_idle;
		!(accept && !hwrite_i) |=> hrdata_o == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

	property p_rd_flags;
		accept && !hwrite_i && reg_hit(haddr_i[11:2], OFS_FLAGS) |=> hrdata_o == {15'h0000, st_reg.flags};
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");

	property p_rd_en;
		accept && !hwrite_i && reg_hit(haddr_i[11:2], OFS_IRQ_EN) |=> hrdata_o == {15'h0000, st_reg.enable};
	endproperty
	a_rd_en: assert property (p_rd_en) else $error("enable read wrong");

	property p_rd_wo;
		accept && !hwrite_i && (reg_hit(haddr_i[11:2], OFS_FLAG_CLR)
			|| reg_hit(haddr_i[11:2], OFS_FLAG_SET)) |=> hrdata_o == 32'h00000000;
	endproperty
	a_rd_wo: assert property (p_rd_wo) else $error("write-only read not zero");

	property p_bit7_zero;
		st_reg.flags[GLOBAL_W] == 1'b0;
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("unused flag bit set");

	property p_en_reserved;
		(st_reg.enable & ~VALID_MASK) == '0;
	endproperty
	a_en_reserved: assert property (p_en_reserved) else $error("unused enable set");

	property p_en_set_wins;
		|(en_set & en_clr) |=> (st_reg.enable & $past(en_set & en_clr)) == $past(en_set & en_clr);
	endproperty
	a_en_set_wins: assert property (p_en_set_wins) else $error("enable clear beat set");

	property p_event_wins;
		|(flag_clr & events) |=> (st_reg.flags[GLOBAL_W-1:0] & $past(flag_clr & events))
			== $past(flag_clr & events);
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("clear beat event");

	property p_global_hold;
		(events | flag_clr | flag_set) == '0 |=> $stable(st_reg.flags[GLOBAL_W-1:0]);
	endproperty
	a_global_hold: assert property (p_global_hold) else $error("flag moved alone");

	property p_frozen_quiet;
		clock_freeze_i && !flag_set[BIT_FRAME] && !st_reg.flags[BIT_FRAME] |=> !st_reg.flags[BIT_FRAME];
	endproperty
	a_frozen_quiet: assert property (p_frozen_quiet) else $error("frame flag while frozen");

	property p_full_speed_ka;
		!low_speed_i && !frame_start_i && !flag_set[BIT_FRAME] && !st_reg.flags[BIT_FRAME]
			|=> !st_reg.flags[BIT_FRAME];
	endproperty
	a_full_speed_ka: assert property (p_full_speed_ka) else $error("keep-alive at full speed");

	property p_no_wake;
		!wake_event && !flag_set[BIT_WAKE] && !st_reg.flags[BIT_WAKE] |=> !st_reg.flags[BIT_WAKE];
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("wake flag without cause");

	property p_ro_enable_write;
		st_reg.wr_pend && reg_hit(st_reg.wr_idx, OFS_IRQ_EN) |=> $stable(st_reg.enable);
	endproperty
	a_ro_enable_write: assert property (p_ro_enable_write) else $error("enable written");

	property p_wr_pend;
		accept |=> st_reg.wr_pend == $past(hwrite_i);
	endproperty
	a_wr_pend: assert property (p_wr_pend) else $error("write not latched");

	property p_frame_irq;
		st_reg.enable[BIT_FRAME] && !clr_en_only[BIT_FRAME] && frame_start_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_frame_irq: assert property (p_frame_irq) else $error("enabled frame no irq");

	property p_pipe_irq;
		st_reg.enable[PIPE_LSB] && !clr_en_only[PIPE_LSB] && pipe_status_i[0] |=> irq_o;
	endproperty
	a_pipe_irq: assert property (p_pipe_irq) else $error("enabled pipe no irq");

	property p_wake_irq;
		st_reg.enable[BIT_WAKE] && !clr_en_only[BIT_WAKE] && wake_event |=> irq_o;
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("enabled wake no irq");

	property p_detach_irq;
		st_reg.enable[BIT_DETACH] && !clr_en_only[BIT_DETACH] && detach_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_detach_irq: assert property (p_detach_irq) else $error("enabled detach no irq");

	property p_attach_irq;
		st_reg.enable[BIT_ATTACH] && !clr_en_only[BIT_ATTACH] && attach_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_attach_irq: assert property (p_attach_irq) else $error("enabled attach no irq");

	property p_rst_irq;
		st_reg.enable[BIT_RST_SENT] && !clr_en_only[BIT_RST_SENT] && reset_done_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("enabled reset sent no irq");

	property p_rsm_sent_irq;
		st_reg.enable[BIT_RSM_SENT] && !clr_en_only[BIT_RSM_SENT] && resume_done_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_rsm_sent_irq: assert property (p_rsm_sent_irq) else $error("enabled resume sent no irq");

	property p_rsm_rx_irq;
		st_reg.enable[BIT_RSM_RX] && !clr_en_only[BIT_RSM_RX] && resume_rx_i && !clock_freeze_i
			|=> irq_o;
	endproperty
	a_rsm_rx_irq: assert property (p_rsm_rx_irq) else $error("enabled resume rx no irq");

	c_frame_irq: cover property (frame_start_i ##1 irq_o);
	c_read_flags: cover property (accept && !hwrite_i && reg_hit(haddr_i[11:2], OFS_FLAGS));
	c_en_set: cover property (|en_set ##1 irq_o);
	c_set_clear_race: cover property (|(flag_clr & events));
	c_wake_frozen: cover property (clock_freeze_i && wake_event);

endmodule : uhgi_ctrl

/* File: uhgi_dev_model.sv */
// Far side of the host port: one-cycle bus event pulses on command
`timescale 1ns/1ps

module uhgi_dev_model (
	// Clock and command
	input  wire logic       sys_clk_i,
	input  wire logic       fire_i,
	input  wire logic [2:0] sel_i,
	// Event pulses, bit 6 is keep-alive
	output logic      [6:0] event_o
);
	// ==========================================================
	// Pulses
	// Follows fire_i every cycle, so a command held for several cycles gives as many event cycles
	logic [6:0] pulse_reg;

	always_ff @(posedge sys_clk_i) begin
		pulse_reg <= fire_i ? (7'h01 << sel_i) : 7'h00;
	end

	assign event_o = pulse_reg;
endmodule : uhgi_dev_model

/* File: uhgi_pkg.sv */
// Constants, register map and state type of the host global interrupt block
package uhgi_pkg;

	// ==========================================================
	// Register map (byte addresses, address bits 11:2 decoded)
	localparam logic [11:0] OFS_FLAGS    = 12'h404;
	localparam logic [11:0] OFS_FLAG_CLR = 12'h408;
	localparam logic [11:0] OFS_FLAG_SET = 12'h40c;
	localparam logic [11:0] OFS_IRQ_EN   = 12'h410;
	localparam logic [11:0] OFS_EN_CLR   = 12'h414;
	localparam logic [11:0] OFS_EN_SET   = 12'h418;

	// ==========================================================
	// Field positions
	localparam int BIT_ATTACH    = 0;
	localparam int BIT_DETACH    = 1;
	localparam int BIT_RST_SENT  = 2;
	localparam int BIT_RSM_SENT  = 3;
	localparam int BIT_RSM_RX    = 4;
	localparam int BIT_FRAME     = 5;
	localparam int BIT_WAKE      = 6;
	localparam int GLOBAL_W      = 7;
	localparam int PIPE_LSB      = 8;
	localparam int PIPE_MSB      = 16;
	localparam int NUM_PIPES     = 9;
	localparam int FLAG_W        = 17;

	localparam logic [FLAG_W-1:0] VALID_MASK  = 17'h1ff7f;
	localparam logic [FLAG_W-1:0] RESET_FLAGS = 17'h00000;
	localparam logic [FLAG_W-1:0] RESET_EN    = 17'h00000;

	// ==========================================================
	// AHB-Lite encodings
	localparam logic       HRESP_OKAY = 1'b0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic [FLAG_W-1:0] flags;
		logic [FLAG_W-1:0] enable;
		logic              wr_pend;
		logic [9:0]        wr_idx;
		logic [31:0]       rdata;
		logic              irq;
		logic              ready;
	} uhgi_state_s;

	localparam uhgi_state_s RESET_STATE = '{
		flags:   RESET_FLAGS,
		enable:  RESET_EN,
		wr_pend: 1'b0,
		wr_idx:  10'h000,
		rdata:   32'h00000000,
		irq:     1'b0,
		ready:   1'b1
	};

endpackage : uhgi_pkg
